// ---- io_field_decode.sv ----
// Purpose: decode one four-bit i/o control field of a general register
// Assumes: field comes straight from a configuration flop
// Notes: a buffered or absent register has all functions off
module io_field_decode
    import timer_cfg_pkg::*;
(
    input wire logic [3:0] i_field,
    input wire logic i_present,
    input wire logic i_buffered,
    output logic o_cmp_en,
    output logic o_cap_en,
    output logic o_init_lvl,
    output logic [1:0] o_match_act,
    output logic [1:0] o_cap_edge
);
    logic live;

    // buffer use overrides the field entirely
    always_comb begin
        live = i_present & ~i_buffered;
        // output disabled is still a compare register, only the pin idles
        o_cmp_en = live & ~i_field[3];
        o_init_lvl = live & ~i_field[3] & i_field[2];
        o_match_act = (live & ~i_field[3]) ? i_field[1:0] : 2'h0;
        // only the pin capture codes 10xx are handled here
        o_cap_en = live & (i_field[3:2] == 2'h2);
        o_cap_edge = 2'h0;
        if (o_cap_en) begin
            o_cap_edge = i_field[1] ? 2'h3 : (i_field[0] ? 2'h2 : 2'h1);
        end
    end
endmodule : io_field_decode

// ---- timer_cfg_pkg.sv ----
// Purpose: shared constants for the timer mode and i/o configuration block
// Assumes: 32-bit avalon-mm slave, one aligned word per register
// Notes: offsets are byte addresses
package timer_cfg_pkg;
    localparam int NUM_CH = 5;
    localparam int NUM_SLOT = 20; // four general register slots per channel, c and d absent on channels 1 and 2
    // register groups, channel n sits at base + 4 * n
    localparam logic [7:0] MODE_BASE = 8'h00;
    localparam logic [7:0] IOAB_BASE = 8'h20;
    localparam logic [7:0] IOCD_BASE = 8'h40;
    localparam logic [7:0] CLKSEL_OFF = 8'h60;
    // channels that own general registers c and d
    localparam logic [4:0] CD_MASK = 5'h19;
    // mode register layout
    localparam int BUF_BD_BIT = 5;
    localparam int BUF_AC_BIT = 4;
    localparam logic [1:0] MODE_FIXED = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'hc0;
    localparam logic [7:0] IO_RESET = 8'h00;
    localparam logic [2:0] CLKSEL_RESET = 3'h0;
    // operating mode codes
    localparam logic [3:0] MD_NORMAL = 4'h0;
    localparam logic [3:0] MD_PWM1 = 4'h2;
    localparam logic [3:0] MD_PWM2 = 4'h3;
    localparam logic [3:0] MD_RSYNC = 4'h8;
    localparam logic [3:0] MD_CPWM_PEAK = 4'hd;
    localparam logic [3:0] MD_CPWM_VALLEY = 4'he;
    localparam logic [3:0] MD_CPWM_BOTH = 4'hf;
    // channel 4 clock source codes
    localparam logic [2:0] CS_DIV1 = 3'h0;
    localparam logic [2:0] CS_DIV4 = 3'h1;
    localparam logic [2:0] CS_DIV16 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FIRST = 3'h6;
    localparam logic [2:0] CS_EXT_SECOND = 3'h7;
    localparam int PRESC_W = 10; // enough for the divide by 1024 tap
endpackage : timer_cfg_pkg

// ---- timer_cfg_top.sv ----
// Purpose: mode, i/o control and channel 4 clock source registers
// Assumes: avalon-mm slave, single clock, standby comes from same clock
// Notes: manual reset has no path here, so it leaves the registers alone
// Functional notes
// - channel 4 codes 000, 001, 011 pick clock undivided, /4, /64
// - channel 4 codes 110 and 111 pick first and second external clock
// - mode registers reset to c0 on power-on or standby only
// - five mode registers; bits 7 and 6 read one, writes ignored
// - bit 5 pairs general registers b and d as buffer
// - bit 4 pairs general registers a and c as buffer
// - buffered register d never captures or compares
// - buffered register c never captures or compares
// - channels 1 and 2 buffer bits read zero, ignore writes
// - mode field: normal, pwm 1, pwm 2, four quadrature modes, reset pwm
// - codes d, e, f give complementary pwm at peak, valley, both
// - reset and complementary pwm only on channel 3; channel 4 follows
// - eight i/o control registers: two on 0, 3, 4; one on 1, 2
// - i/o control registers reset to zero on power-on or standby
// - first i/o register: high nibble is b, low nibble is a
// - second i/o register: high nibble is d, low nibble is c
// - buffered c or d ignores its i/o field
// - top bit clear: compare, bit 2 initial level, low bits action
// - codes 1000, 1001, 101x capture on rising, falling, both edges
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
module timer_cfg_top
    import timer_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_standby,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_ext_clock_in_first,
    input wire logic i_ext_clock_in_second,
    output logic o_ch4_count_tick,
    output logic [19:0] o_eff_mode,
    output logic [4:0] o_pwm1,
    output logic [4:0] o_pwm2,
    output logic [4:0] o_phase,
    output logic [4:0] o_rsync,
    output logic [4:0] o_compl,
    output logic [1:0] o_compl_xfer,
    output logic [4:0] o_buffer_pair_a_c,
    output logic [4:0] o_buffer_pair_b_d,
    output logic [19:0] o_cmp_en,
    output logic [19:0] o_cap_en,
    output logic [19:0] o_init_lvl,
    output logic [39:0] o_match_act,
    output logic [39:0] o_cap_edge
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [4:0][3:0] op_mode_field;
        logic [4:0] buffer_pair_a_c;
        logic [4:0] buffer_pair_b_d;
        logic [4:0][7:0] io_ab;
        logic [4:0][7:0] io_cd;
        logic [2:0] clock_source_field;
        logic [PRESC_W-1:0] presc;
        logic [2:0] ext_a;
        logic [2:0] ext_b;
        logic tick;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic req;
    logic wr_take;
    logic [2:0] grp;
    logic [2:0] ch;
    logic ch_ok;
    logic couple;

    // release reset through two flops so every flop leaves reset together
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // bus decode; a word is answered one cycle after the request rises
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~s_q.ack;
    assign wr_take = s_q.ack & i_avs_write & i_avs_byteenable[0];
    assign grp = i_avs_address[7:5];
    assign ch = i_avs_address[4:2];
    assign ch_ok = (ch < 3'(NUM_CH));
    assign o_avs_readdata = s_q.rdata;

    // read view, fixed and reserved bits forced on every read
    function automatic logic [31:0] rd_word(input state_t s,
                                            input logic [2:0] g,
                                            input logic [2:0] c,
                                            input logic ok);
        logic [31:0] w;
        w = 32'h0;
        if (ok && g == IOAB_BASE[7:5]) begin
            w[7:0] = s.io_ab[c];
        end else if (ok && g == IOCD_BASE[7:5] && CD_MASK[c]) begin
            w[7:0] = s.io_cd[c];
        end else if (ok && g == MODE_BASE[7:5]) begin
            w[7:0] = {MODE_FIXED, s.buffer_pair_b_d[c],
                      s.buffer_pair_a_c[c], s.op_mode_field[c]};
        end else if (g == CLKSEL_OFF[7:5] && c == 3'h0) begin
            w[2:0] = s.clock_source_field;
        end
        return w;
    endfunction : rd_word

    // one next-state copy for the whole block
    always_comb begin
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack) begin
            s_d.rdata = rd_word(s_q, grp, ch, ch_ok);
        end
        s_d.presc = s_q.presc + PRESC_W'(1);
        s_d.ext_a = {s_q.ext_a[1:0], i_ext_clock_in_first};
        s_d.ext_b = {s_q.ext_b[1:0], i_ext_clock_in_second};
        // writes land only at the edge where waitrequest is low
        if (wr_take && ch_ok && grp == MODE_BASE[7:5]) begin
            s_d.op_mode_field[ch] = i_avs_writedata[3:0];
            if (CD_MASK[ch]) begin
                s_d.buffer_pair_a_c[ch] = i_avs_writedata[BUF_AC_BIT];
                s_d.buffer_pair_b_d[ch] = i_avs_writedata[BUF_BD_BIT];
            end
        end
        if (wr_take && ch_ok && grp == IOAB_BASE[7:5]) begin
            s_d.io_ab[ch] = i_avs_writedata[7:0];
        end
        if (wr_take && ch_ok && grp == IOCD_BASE[7:5] && CD_MASK[ch]) begin
            s_d.io_cd[ch] = i_avs_writedata[7:0];
        end
        if (wr_take && grp == CLKSEL_OFF[7:5] && ch == 3'h0) begin
            s_d.clock_source_field = i_avs_writedata[2:0];
        end
        // standby reinitialises configuration, not the bus or prescaler
        if (i_standby) begin
            s_d.op_mode_field = '0;
            s_d.buffer_pair_a_c = MODE_RESET[4:0];
            s_d.buffer_pair_b_d = '0;
            s_d.io_ab = '0;
            s_d.io_cd = '0;
            s_d.clock_source_field = CLKSEL_RESET;
        end
        // channel 4 counter clock selection
        case (s_q.clock_source_field)
            CS_DIV1: s_d.tick = 1'b1;
            CS_DIV4: s_d.tick = &s_q.presc[1:0];
            CS_DIV16: s_d.tick = &s_q.presc[3:0];
            CS_DIV64: s_d.tick = &s_q.presc[5:0];
            CS_DIV256: s_d.tick = &s_q.presc[7:0];
            CS_DIV1024: s_d.tick = &s_q.presc[9:0];
            CS_EXT_FIRST: s_d.tick = s_q.ext_a[1] & ~s_q.ext_a[2];
            CS_EXT_SECOND: s_d.tick = s_q.ext_b[1] & ~s_q.ext_b[2];
            default: s_d.tick = 1'b0;
        endcase
    end

    // single register stage for the whole state
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_ch4_count_tick = s_q.tick;
    assign o_buffer_pair_a_c = s_q.buffer_pair_a_c;
    assign o_buffer_pair_b_d = s_q.buffer_pair_b_d;

    // channel 3 in reset or complementary pwm drags channel 4 along
    always_comb begin
        couple = (s_q.op_mode_field[3] == MD_RSYNC) ||
                 (s_q.op_mode_field[3] == MD_CPWM_PEAK) ||
                 (s_q.op_mode_field[3] == MD_CPWM_VALLEY) ||
                 (s_q.op_mode_field[3] == MD_CPWM_BOTH);
    end

    // per-channel mode decode; reserved codes simply decode to nothing
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            logic [3:0] md;
            logic sync_ok;
            assign md = (gc == 4 && couple) ? s_q.op_mode_field[3]
                                            : s_q.op_mode_field[gc];
            assign sync_ok = (gc == 3) || (gc == 4 && couple);
            assign o_eff_mode[gc*4 +: 4] = md;
            assign o_pwm1[gc] = (md == MD_PWM1);
            assign o_pwm2[gc] = (md == MD_PWM2);
            assign o_phase[gc] = (md[3:2] == 2'h1);
            assign o_rsync[gc] = sync_ok & (md == MD_RSYNC);
            assign o_compl[gc] = sync_ok & (md[3:2] == 2'h3) &
                                 (md[1:0] != 2'h0);
        end
    endgenerate
    // bit 0 transfer at peak, bit 1 transfer at valley
    always_comb begin
        o_compl_xfer = 2'h0;
        if (o_compl[3]) begin
            o_compl_xfer[0] = (s_q.op_mode_field[3] != MD_CPWM_VALLEY);
            o_compl_xfer[1] = (s_q.op_mode_field[3] != MD_CPWM_PEAK);
        end
    end

    // slot = channel * 4 + register, registers ordered a, b, c, d
    genvar gs;
    generate
        for (gs = 0; gs < NUM_SLOT; gs++) begin : g_slot
            localparam int CH = gs / 4;
            localparam int RG = gs % 4;
            logic [3:0] fld;
            logic present;
            logic buffered;
            // high nibble drives b or d, low nibble a or c
            assign fld = (RG == 0) ? s_q.io_ab[CH][3:0] :
                         (RG == 1) ? s_q.io_ab[CH][7:4] :
                         (RG == 2) ? s_q.io_cd[CH][3:0] :
                                     s_q.io_cd[CH][7:4];
            assign present = (RG < 2) || CD_MASK[CH];
            assign buffered = (RG == 2) ? s_q.buffer_pair_a_c[CH] :
                              (RG == 3) ? s_q.buffer_pair_b_d[CH] :
                                          1'b0;
            io_field_decode u_dec (
                .i_field(fld),
                .i_present(present),
                .i_buffered(buffered),
                .o_cmp_en(o_cmp_en[gs]),
                .o_cap_en(o_cap_en[gs]),
                .o_init_lvl(o_init_lvl[gs]),
                .o_match_act(o_match_act[gs*2 +: 2]),
                .o_cap_edge(o_cap_edge[gs*2 +: 2])
            );
        end
    endgenerate

    // checks on the decode and the bus timing
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    // a fresh request must never find a stale acknowledge
    property p_wait_first;
        $rose(req) |-> o_avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("waitrequest low on first request cycle");

    property p_answer_one;
        (req && o_avs_waitrequest) ##1 req |-> !o_avs_waitrequest;
    endproperty
    a_answer_one: assert property (p_answer_one)
        else $error("held request not answered after one cycle");

    property p_fixed_bits;
        (s_q.ack && i_avs_read && grp == 3'h0 && ch_ok) |->
            (o_avs_readdata[7:6] == MODE_FIXED);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("mode register fixed bits not read as one");

    property p_no_buf_ch12;
        (s_q.buffer_pair_a_c[2:1] == 2'h0) &&
            (s_q.buffer_pair_b_d[2:1] == 2'h0);
    endproperty
    a_no_buf_ch12: assert property (p_no_buf_ch12)
        else $error("buffer bit set on channel 1 or 2");

    property p_standby_clear;
        i_standby |=> (s_q.op_mode_field == '0) && (s_q.io_ab == '0) &&
                      (s_q.io_cd == '0);
    endproperty
    a_standby_clear: assert property (p_standby_clear)
        else $error("standby left configuration set");

    property p_follow;
        couple |-> (o_eff_mode[19:16] == o_eff_mode[15:12]) &&
                   (o_rsync[4] == o_rsync[3]) && (o_compl[4] == o_compl[3]);
    endproperty
    a_follow: assert property (p_follow)
        else $error("channel 4 does not follow channel 3");

    property p_buf_c;
        s_q.buffer_pair_a_c[0] |-> !o_cmp_en[2] && !o_cap_en[2];
    endproperty
    a_buf_c: assert property (p_buf_c)
        else $error("buffered register c still active");

    property p_buf_d;
        s_q.buffer_pair_b_d[3] |-> !o_cmp_en[15] && !o_cap_en[15];
    endproperty
    a_buf_d: assert property (p_buf_d)
        else $error("buffered register d still active");

    property p_div4;
        (s_q.clock_source_field == CS_DIV4 && s_q.presc[1:0] == 2'h3 &&
         !i_standby && !wr_take) ##1 1'b1 ##1 1'b1 |->
            $past(o_ch4_count_tick) && !o_ch4_count_tick;
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by four tick misplaced");

    property p_ext_first;
        (s_q.clock_source_field == CS_EXT_FIRST && s_q.ext_a[1] &&
         !s_q.ext_a[2]) |=> o_ch4_count_tick;
    endproperty
    a_ext_first: assert property (p_ext_first)
        else $error("first external clock edge not counted");

    property p_mode_write;
        (wr_take && grp == 3'h0 && ch == 3'h0 && !i_standby) |=>
            (s_q.op_mode_field[0] == $past(i_avs_writedata[3:0]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode field write lost");

    property p_io_cd_write;
        (wr_take && grp == 3'h2 && ch == 3'h3 && !i_standby) |=>
            (s_q.io_cd[3] == $past(i_avs_writedata[7:0]));
    endproperty
    a_io_cd_write: assert property (p_io_cd_write)
        else $error("channel 3 second i/o register write lost");

    property p_xfer_both;
        (s_q.op_mode_field[3] == MD_CPWM_BOTH) |-> (o_compl_xfer == 2'h3);
    endproperty
    a_xfer_both: assert property (p_xfer_both)
        else $error("peak and valley transfer not both flagged");

    c_write_take: cover property (wr_take);
    c_read_mode: cover property (s_q.ack && i_avs_read && grp == 3'h0);
    c_couple: cover property (couple);
    c_buffered: cover property (s_q.buffer_pair_a_c[0]);
endmodule : timer_cfg_top

// ---- timer_channel_mode_io_config_tb_top.sv ----
// Purpose: self-checking bench for the timer mode and i/o config block
// Assumes: legal settings only, reserved and forbidden codes never written
// Notes: expectations come from bench mirrors, never from the design
module timer_channel_mode_io_config_tb_top
    import timer_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic standby = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [1:0] ext = 2'h0;
    logic [31:0] rdata;
    logic wait_req, tick;
    logic [19:0] eff_mode, cmp_en, cap_en, init_lvl;
    logic [4:0] pwm1, pwm2, phase, rsync, compl, bac, bbd;
    logic [1:0] cxfer;
    logic [39:0] mact, cedge;
    int error_cnt = 0;
    int checks = 0;
    int seed = 43873;
    int tick_cnt = 0;
    logic [7:0] mode_m[5], ioab_m[5], iocd_m[5];

    always #4 mclk = ~mclk;
    // running tick count, windows take differences so no reset race
    always @(posedge mclk) if (tick === 1'b1) tick_cnt <= tick_cnt + 1;

    timer_cfg_top timer_cfg_top_i (.i_mclk(mclk), .i_rst_n(rst_n),
        .i_standby(standby), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_ext_clock_in_first(ext[0]), .i_ext_clock_in_second(ext[1]),
        .o_ch4_count_tick(tick), .o_eff_mode(eff_mode), .o_pwm1(pwm1),
        .o_pwm2(pwm2), .o_phase(phase), .o_rsync(rsync), .o_compl(compl),
        .o_compl_xfer(cxfer), .o_buffer_pair_a_c(bac),
        .o_buffer_pair_b_d(bbd), .o_cmp_en(cmp_en), .o_cap_en(cap_en),
        .o_init_lvl(init_lvl), .o_match_act(mact), .o_cap_edge(cedge));

    task automatic end_of_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [39:0] e,
                       input logic [39:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_cnt(input string nm, input int e, input int g);
        checks++;
        if (g != e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        logic seen;
        @(posedge mclk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        // look mid-cycle where the answer has settled, act on the next edge
        do begin
            @(negedge mclk);
            seen = wait_req;
            q = rdata;
            @(posedge mclk);
        end while (seen !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask : wr_reg

    // address rides in the top byte so a mismatch names the register
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'h0, q);
        chk("readdata", {a, 24'h0, e}, {a, q});
    endtask : chk_rd

    function automatic logic [7:0] mode_rb(int c, logic [7:0] d);
        logic [7:0] v;
        v = {2'b11, d[5:0]};
        if (c == 1 || c == 2) v[5:4] = 2'b00;
        return v;
    endfunction : mode_rb

    // only codes that software may legally put on each channel
    function automatic logic [3:0] pick_md(int c, int r);
        logic [3:0] t3[6] = '{MD_NORMAL, MD_PWM1, MD_RSYNC, MD_CPWM_PEAK,
                               MD_CPWM_VALLEY, MD_CPWM_BOTH};
        logic [3:0] t0[3] = '{MD_NORMAL, MD_PWM1, MD_PWM2};
        if (c == 3) return t3[r % 6];
        if (c == 4) return t0[r % 2];
        if ((c == 1 || c == 2) && r[5]) return {2'b01, 2'(r)};
        return t0[r % 3];
    endfunction : pick_md

    // {cmp, cap, init, act[1:0], edge[1:0]} of one general register
    function automatic logic [6:0] fdec(logic [3:0] f, logic on);
        if (!on || f[3:2] == 2'b11) return 7'h00;
        if (!f[3]) return {1'b1, 1'b0, f[2], f[1:0], 2'b00};
        return {5'b01000, f[1] ? 2'b11 : (f[0] ? 2'b10 : 2'b01)};
    endfunction : fdec

    task automatic check_all();
        logic [19:0] ecmp, ecap, einit, emd;
        logic [39:0] eact, eedg;
        logic [4:0] ep1, ep2, eph, ers, ecp, eba, ebb;
        logic [6:0] v;
        logic [3:0] f, m, m3;
        logic on;
        @(negedge mclk);
        m3 = mode_m[3][3:0];
        for (int s = 0; s < 20; s++) begin
            f = (s % 4 < 2) ? ioab_m[s / 4][4 * (s % 2) +: 4]
                            : iocd_m[s / 4][4 * (s % 2) +: 4];
            on = (s % 4 < 2) || CD_MASK[s / 4];
            if (s % 4 == 2 && mode_m[s / 4][4]) on = 1'b0;
            if (s % 4 == 3 && mode_m[s / 4][5]) on = 1'b0;
            v = fdec(f, on);
            {ecmp[s], ecap[s], einit[s]} = v[6:4];
            eact[2 * s +: 2] = v[3:2];
            eedg[2 * s +: 2] = v[1:0];
        end
        for (int c = 0; c < 5; c++) begin
            m = mode_m[c][3:0];
            if (c == 4 && (m3 == MD_RSYNC || m3 >= MD_CPWM_PEAK)) m = m3;
            emd[4 * c +: 4] = m;
            ep1[c] = (m == MD_PWM1);
            ep2[c] = (m == MD_PWM2);
            eph[c] = (m[3:2] == 2'b01);
            ers[c] = (m == MD_RSYNC);
            ecp[c] = (m >= MD_CPWM_PEAK);
            {ebb[c], eba[c]} = mode_m[c][5:4];
        end
        chk("cmp_en", 40'(ecmp), 40'(cmp_en));
        chk("cap_en", 40'(ecap), 40'(cap_en));
        chk("init_lvl", 40'(einit), 40'(init_lvl));
        chk("match_act", eact, mact);
        chk("cap_edge", eedg, cedge);
        chk("eff_mode", 40'(emd), 40'(eff_mode));
        chk("flags", 40'({ep1, ep2, eph, ers, ecp}),
            40'({pwm1, pwm2, phase, rsync, compl}));
        chk("buffer_bits", 40'({eba, ebb}),
            40'({bac, bbd}));
        chk("compl_xfer", 40'(ecp[3] ? m3[1:0] : 2'b00),
            40'(cxfer));
    endtask : check_all

    task automatic check_regs();
        for (int c = 0; c < 5; c++) begin
            chk_rd(MODE_BASE + 8'(4 * c), mode_m[c]);
            chk_rd(IOAB_BASE + 8'(4 * c), ioab_m[c]);
            chk_rd(IOCD_BASE + 8'(4 * c), iocd_m[c]);
        end
        check_all();
    endtask : check_regs

    task automatic to_reset();
        for (int c = 0; c < 5; c++) begin
            mode_m[c] = MODE_RESET;
            ioab_m[c] = IO_RESET;
            iocd_m[c] = IO_RESET;
        end
    endtask : to_reset

    // watchdog sized well above the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [2:0] cs[3];
        int ex[3];
        int t0, n;
        cs = '{CS_DIV1, CS_DIV4, CS_DIV64};
        ex = '{256, 64, 4};
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        to_reset();
        check_regs();
        // first six passes walk channel 3 through all its codes
        for (int it = 0; it < 20; it++) begin
            for (int c = 0; c < 5; c++) begin
                d = $random(seed);
                d[3:0] = pick_md(c, (it < 6 && c == 3) ? it : int'(d[15:8]));
                mode_m[c] = mode_rb(c, d[7:0]);
                wr_reg(MODE_BASE + 8'(4 * c), d, 4'($random(seed)) | 4'h1);
                d = $random(seed);
                ioab_m[c] = d[7:0];
                wr_reg(IOAB_BASE + 8'(4 * c), d, 4'h1);
                d = $random(seed);
                if (CD_MASK[c]) iocd_m[c] = d[7:0];
                wr_reg(IOCD_BASE + 8'(4 * c), d, 4'h1);
            end
            check_regs();
            // mid-run power-on reset must bring back the same values
            if (it == 9) begin
                rst_n <= 1'b0;
                repeat (12) @(posedge mclk);
                rst_n <= 1'b1;
                repeat (4) @(posedge mclk);
                to_reset();
                check_regs();
            end
        end
        // lane 0 disabled: write must be dropped
        wr_reg(MODE_BASE, ~{24'h0, mode_m[0]}, 4'he);
        chk_rd(MODE_BASE, mode_m[0]);
        chk_rd(8'h7c, 8'h00);
        // internal dividers, window is a multiple of every period
        for (int k = 0; k < 3; k++) begin
            wr_reg(CLKSEL_OFF, 32'(cs[k]), 4'h1);
            chk_rd(CLKSEL_OFF, 8'(cs[k]));
            repeat (4) @(posedge mclk);
            t0 = tick_cnt;
            repeat (256) @(posedge mclk);
            chk_cnt("tick_div", ex[k], tick_cnt - t0);
        end
        // the unselected pin pulses too and must not count
        for (int k = 0; k < 2; k++) begin
            wr_reg(CLKSEL_OFF, 32'(CS_EXT_FIRST + 3'(k)), 4'h1);
            chk_rd(CLKSEL_OFF, 8'(CS_EXT_FIRST + 3'(k)));
            repeat (8) @(posedge mclk);
            t0 = tick_cnt;
            repeat (10) begin
                n = 3 + ($random(seed) & 3);
                ext <= 2'b01 << k;
                repeat (n) @(posedge mclk);
                ext <= 2'b10 >> k;
                repeat (n) @(posedge mclk);
            end
            ext <= 2'b00;
            repeat (8) @(posedge mclk);
            chk_cnt("tick_ext", 10, tick_cnt - t0);
        end
        // standby clears all configuration back to power-on values
        @(posedge mclk);
        standby <= 1'b1;
        @(posedge mclk);
        standby <= 1'b0;
        to_reset();
        check_regs();
        end_of_test();
    end
endmodule : timer_channel_mode_io_config_tb_top
